// ==== src/psq_consts.svh ====
// Register offsets, field positions, reset values and sizes of the sample queue
`ifndef PSQ_CONSTS_SVH
`define PSQ_CONSTS_SVH

// Register byte offsets
`define PSQ_ADDR_CTRL 8'h13
`define PSQ_ADDR_THR 8'h14
`define PSQ_ADDR_REF_LO 8'h15
`define PSQ_ADDR_REF_HI 8'h16
`define PSQ_ADDR_OFS_LO 8'h18
`define PSQ_ADDR_OFS_HI 8'h19
`define PSQ_ADDR_CAUSE 8'h24
`define PSQ_ADDR_FILL 8'h25
`define PSQ_ADDR_Q_PRESS_LO 8'h78
`define PSQ_ADDR_Q_PRESS_MID 8'h79
`define PSQ_ADDR_Q_PRESS_HI 8'h7a
`define PSQ_ADDR_Q_TEMP_LO 8'h7b
`define PSQ_ADDR_Q_TEMP_HI 8'h7c

// Queue control field positions
`define PSQ_CTRL_STOP_BIT 3
`define PSQ_CTRL_TRIG_BIT 2

// Interrupt cause field positions
`define PSQ_CAUSE_BOOT_BIT 7
`define PSQ_CAUSE_IA_BIT 2
`define PSQ_CAUSE_PL_BIT 1
`define PSQ_CAUSE_PH_BIT 0

// Reset values
`define PSQ_CTRL_RESET 4'h0
`define PSQ_THR_RESET 7'h00
`define PSQ_BYTE_RESET 8'h00

// Sizes
`define PSQ_QUEUE_DEPTH 128
`define PSQ_BUF_DEPTH 16
`define PSQ_PRESS_W 24
`define PSQ_TEMP_W 16

`endif

// ==== src/psq_pkg.sv ====
// Types shared by the sample queue control logic
`include "psq_consts.svh"
package psq_pkg;
   // Effective queue behaviour after trigger decoding
   typedef enum logic [1:0] {
      PSQ_BYPASS = 2'b00,
      PSQ_STORE = 2'b01,
      PSQ_STREAM = 2'b10
   } psq_mode_e;
   // One queued sample: temperature above pressure
   typedef logic [`PSQ_PRESS_W+`PSQ_TEMP_W-1:0] psq_sample_t;
endpackage : psq_pkg

// ==== src/psq_fifo.sv ====
// Parameterised FIFO with registered head word and valid/ready both sides
module psq_fifo
   import psq_pkg::*;
#(
   parameter int WIDTH = 40,
   parameter int DEPTH = 16,
   localparam int AW = $clog2(DEPTH),
   localparam int LW = $clog2(DEPTH + 1)
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic flush,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData,
   output logic [LW-1:0] level
);
   // Pointers wrap naturally only for powers of two
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("psq_fifo depth must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset
   logic [AW-1:0] wrPtr_ff; // Next slot to write
   logic [AW-1:0] rdPtr_ff; // Oldest slot
   logic [AW-1:0] nxt_rdPtr; // Oldest slot after this cycle
   logic [LW-1:0] level_ff; // Words held
   logic notFull_ff; // Room for one more word
   logic [WIDTH-1:0] head_ff; // Copy of the oldest word
   logic wrEn; // Word accepted
   logic rdEn; // Word removed

   // A push into a full FIFO is taken when a pop frees a slot alike
   assign rdEn = outReady && (level_ff != '0);
   assign wrEn = inValid && (notFull_ff || rdEn);
   assign nxt_rdPtr = rdEn ? rdPtr_ff + AW'(1) : rdPtr_ff;
   assign inReady = notFull_ff;
   assign outValid = (level_ff != '0);
   assign outData = head_ff;
   assign level = level_ff;

   // Storage write
   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrPtr_ff] <= inData;
      end
   end

   // Pointers, level and full flag
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         level_ff <= '0;
         notFull_ff <= 1'b1;
      end else if (flush) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         level_ff <= '0;
         notFull_ff <= 1'b1;
      end else begin
         if (wrEn) begin
            wrPtr_ff <= wrPtr_ff + AW'(1);
         end
         rdPtr_ff <= nxt_rdPtr;
         case ({wrEn, rdEn})
            2'b10: begin
               level_ff <= level_ff + LW'(1);
               notFull_ff <= (level_ff != LW'(DEPTH - 1));
            end
            2'b01: begin
               level_ff <= level_ff - LW'(1);
               notFull_ff <= 1'b1;
            end
            default: begin
               level_ff <= level_ff;
            end
         endcase
      end
   end

   // Head word, bypassing a write into the slot about to be read
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         head_ff <= '0;
      end else if (wrEn && (wrPtr_ff == nxt_rdPtr)) begin
         head_ff <= inData;
      end else begin
         head_ff <= mem[nxt_rdPtr];
      end
   end

   // Level never passes the depth
   a_fifo_bound: assert property (@(posedge clk) disable iff (!reset_n)
      level_ff <= LW'(DEPTH))
      else $error("FIFO level above depth");
   // Full flag agrees with the level
   a_fifo_full: assert property (@(posedge clk) disable iff (!reset_n)
      !notFull_ff |-> level_ff == LW'(DEPTH))
      else $error("FIFO full flag without full level");
endmodule : psq_fifo

// ==== src/psq_sample_queue_ctrl.sv ====
// Sample queue control, reference and offset storage, interrupt cause
`include "psq_consts.svh"

module psq_sample_queue_ctrl
   import psq_pkg::*;
#(
   parameter int QUEUE_DEPTH = `PSQ_QUEUE_DEPTH,
   parameter int BUF_DEPTH = `PSQ_BUF_DEPTH
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic accessStart,
   input wire logic [7:0] accessAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regWrData,
   input wire logic addrAutoInc,
   output logic [7:0] rdData,
   output logic rdValid,
   input wire logic sampleValid,
   input wire logic [`PSQ_PRESS_W-1:0] samplePressure,
   input wire logic [`PSQ_TEMP_W-1:0] sampleTemperature,
   output logic sampleReady,
   input wire logic bootRunning,
   input wire logic pressureHighEvent,
   input wire logic pressureLowEvent,
   input wire logic zeroOnEnableMode,
   input wire logic referenceCaptureMode,
   input wire logic refLoad,
   input wire logic [15:0] refValue,
   output logic [15:0] referencePressure,
   output logic thresholdReached,
   output logic queueOverwrite,
   output logic queueFull
);
   // Fill register is eight bits wide and counts up to 128
   if (QUEUE_DEPTH < 2 || QUEUE_DEPTH > 128 ||
       (QUEUE_DEPTH & (QUEUE_DEPTH - 1)) != 0) begin : g_bad_queue
      $error("Queue depth must be a power of two from 2 to 128");
   end
   if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad_buf
      $error("Buffer depth must be a power of two, at least 2");
   end

   localparam int QLW = $clog2(QUEUE_DEPTH + 1);

   // Host access
   logic [7:0] addr_ff; // Address pointer of the running access
   logic [7:0] curAddr; // Address of the byte in this cycle
   logic [7:0] nxt_addr; // Pointer after this byte
   logic byteWrite; // Host writes a byte
   logic byteRead; // Host reads a byte
   logic [7:0] rdByte; // Selected read byte
   logic [7:0] rdData_ff; // Registered read data
   logic rdValid_ff; // Read data valid pulse
   logic readLock_ff; // Queue word partly read
   // Configuration
   logic [3:0] ctrl_ff; // Stop, trigger, mode[1:0]
   logic [6:0] thr_ff; // Threshold level
   logic [15:0] ofs_ff; // Pressure offset
   logic [15:0] ref_ff; // Reference pressure
   // Interrupt cause
   logic [1:0] diffEvent; // Low, high events
   logic [1:0] diffFlag_ff; // Low, high latched flags
   logic [1:0] nxt_diffFlag; // Flags after this cycle
   logic iaFlag_ff; // Any event latched
   logic bootFlag_ff; // Boot phase running
   logic causeRead; // Cause register read
   // Queue control
   psq_mode_e effMode; // Behaviour in force
   logic trigSeen_ff; // Trigger taken in triggered modes
   logic [`PSQ_PRESS_W-1:0] corrPressure; // Pressure minus offset
   psq_sample_t bufInData; // Word into the ingress buffer
   psq_sample_t bufData; // Oldest buffered word
   logic bufValid; // Ingress buffer holds a word
   logic bufPop; // Take word from the buffer
   logic qPush; // Store word in the queue
   logic qNotFull; // Queue storage has room
   logic qValid; // Queue holds a word
   logic qPop; // Remove oldest queue word
   logic hostPop; // Host finished reading a word
   logic dropOldest; // Oldest word overwritten
   logic qFlush; // Empty the queue
   logic qLimit; // Queue counts as full
   psq_sample_t qHead; // Oldest queued word
   logic [QLW-1:0] qLevelRaw; // Queue level, native width
   logic [7:0] qLevel; // Queue level, register width
   logic thrReached_ff; // Level at or above threshold
   logic overwrite_ff; // Sample overwritten while full
   logic full_ff; // Queue counts as full

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Byte strobes; a write wins over a read in the same cycle
   assign byteWrite = regWrite;
   assign byteRead = regRead && !regWrite;
   assign curAddr = accessStart ? accessAddr : addr_ff;
   assign causeRead = byteRead && (curAddr == `PSQ_ADDR_CAUSE);

   // Next address; queue bursts wrap from the last byte to the first
   always_comb begin
      if (!addrAutoInc) begin
         nxt_addr = curAddr;
      end else if (curAddr == `PSQ_ADDR_Q_TEMP_HI) begin
         nxt_addr = `PSQ_ADDR_Q_PRESS_LO;
      end else begin
         nxt_addr = curAddr + 8'h01;
      end
   end

   // Address pointer of the multi-byte access
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         addr_ff <= `PSQ_BYTE_RESET;
      end else if (byteWrite || byteRead) begin
         addr_ff <= nxt_addr;
      end else if (accessStart) begin
         addr_ff <= accessAddr;
      end
   end

   // Writable configuration; the read-only reference ignores writes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_ff <= `PSQ_CTRL_RESET;
         thr_ff <= `PSQ_THR_RESET;
         ofs_ff <= {`PSQ_BYTE_RESET, `PSQ_BYTE_RESET};
      end else if (byteWrite) begin
         case (curAddr)
            `PSQ_ADDR_CTRL: ctrl_ff <= regWrData[3:0];
            `PSQ_ADDR_THR: thr_ff <= regWrData[6:0];
            `PSQ_ADDR_OFS_LO: ofs_ff[7:0] <= regWrData;
            `PSQ_ADDR_OFS_HI: ofs_ff[15:8] <= regWrData;
            default: ctrl_ff <= ctrl_ff;
         endcase
      end
   end

   // Reference loaded by the device only in an auto mode
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ref_ff <= {`PSQ_BYTE_RESET, `PSQ_BYTE_RESET};
      end else if (refLoad && (zeroOnEnableMode || referenceCaptureMode)) begin
         ref_ff <= refValue;
      end
   end

   // Reference held steady outside the auto modes and against host writes
   a_ref_hold: assert property (
      !(refLoad && (zeroOnEnableMode || referenceCaptureMode))
      |=> $stable(ref_ff))
      else $error("Reference changed without an auto-mode load");

   // Differential pressure flags, set wins over the read clear
   assign diffEvent = {pressureLowEvent, pressureHighEvent};
   for (genvar gi = 0; gi < 2; gi++) begin : g_diff
      assign nxt_diffFlag[gi] = diffEvent[gi] ||
                                (diffFlag_ff[gi] && !causeRead);
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            diffFlag_ff[gi] <= 1'b0;
         end else begin
            diffFlag_ff[gi] <= nxt_diffFlag[gi];
         end
      end
   end

   // Interrupt active and boot indication
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         iaFlag_ff <= 1'b0;
         bootFlag_ff <= 1'b0;
      end else begin
         iaFlag_ff <= |nxt_diffFlag;
         bootFlag_ff <= bootRunning;
      end
   end

   // An event is never lost, even under a clearing read
   a_low_sticky: assert property (
      pressureLowEvent |=> diffFlag_ff[1] && iaFlag_ff)
      else $error("Low pressure event not latched");
   a_high_sticky: assert property (
      pressureHighEvent ##1 !pressureHighEvent && !causeRead
      |=> diffFlag_ff[0] && iaFlag_ff)
      else $error("High pressure flag did not hold");
   a_ia_tracks: assert property (
      iaFlag_ff == (diffFlag_ff[0] || diffFlag_ff[1]))
      else $error("Interrupt active disagrees with event flags");

   // Trigger latch; a pending trigger wins over a reconfiguring write
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trigSeen_ff <= 1'b0;
      end else begin
         trigSeen_ff <= (trigSeen_ff &&
                         !(byteWrite && curAddr == `PSQ_ADDR_CTRL)) ||
                        (ctrl_ff[`PSQ_CTRL_TRIG_BIT] && iaFlag_ff);
      end
   end

   // Mode decoding from trigger enable, mode field and trigger latch
   always_comb begin
      case ({ctrl_ff[`PSQ_CTRL_TRIG_BIT], ctrl_ff[1:0]})
         3'b0_00, 3'b1_00: effMode = PSQ_BYPASS;
         3'b0_01: effMode = PSQ_STORE;
         3'b0_10, 3'b0_11: effMode = PSQ_STREAM;
         3'b1_01: effMode = trigSeen_ff ? PSQ_STORE : PSQ_BYPASS;
         3'b1_10: effMode = trigSeen_ff ? PSQ_STREAM : PSQ_BYPASS;
         3'b1_11: effMode = trigSeen_ff ? PSQ_STORE : PSQ_STREAM;
         default: effMode = PSQ_BYPASS;
      endcase
   end

   a_mode_bypass: assert property (
      ctrl_ff[1:0] == 2'b00 |-> effMode == PSQ_BYPASS)
      else $error("Mode 00 not decoded as bypass");
   a_mode_stream: assert property (
      !ctrl_ff[`PSQ_CTRL_TRIG_BIT] && ctrl_ff[1] |-> effMode == PSQ_STREAM)
      else $error("Untriggered mode 1x not continuous");

   // Trigger moves any triggered mode to its second behaviour
   sequence s_armed;
      ctrl_ff[2] && ctrl_ff[1:0] != 2'b00 && !trigSeen_ff;
   endsequence
   sequence s_fired;
      iaFlag_ff && !(byteWrite && curAddr == `PSQ_ADDR_CTRL);
   endsequence
   a_trig_switch: assert property (
      s_armed ##0 s_fired
      |=> effMode == (ctrl_ff[1:0] == 2'b10 ? PSQ_STREAM : PSQ_STORE))
      else $error("Triggered mode did not switch on interrupt");

   // Ingress word carries offset-corrected pressure
   assign corrPressure = samplePressure -
                         {{8{ofs_ff[15]}}, ofs_ff};
   assign bufInData = {sampleTemperature, corrPressure};

   // Ingress buffer; its ready reaches the measurement side
   psq_fifo #(
      .WIDTH($bits(psq_sample_t)),
      .DEPTH(BUF_DEPTH)
   ) u_ingress (
      .clk(clk),
      .reset_n(reset_n),
      .flush(1'b0),
      .inValid(sampleValid),
      .inReady(sampleReady),
      .inData(bufInData),
      .outValid(bufValid),
      .outReady(bufPop),
      .outData(bufData),
      .level()
   );

   // Queue storage
   psq_fifo #(
      .WIDTH($bits(psq_sample_t)),
      .DEPTH(QUEUE_DEPTH)
   ) u_queue (
      .clk(clk),
      .reset_n(reset_n),
      .flush(qFlush),
      .inValid(qPush),
      .inReady(qNotFull),
      .inData(bufData),
      .outValid(qValid),
      .outReady(qPop),
      .outData(qHead),
      .level(qLevelRaw)
   );

   assign qLevel = 8'(qLevelRaw);
   assign qFlush = (effMode == PSQ_BYPASS);
   assign hostPop = byteRead && qValid &&
                    (curAddr == `PSQ_ADDR_Q_TEMP_HI);
   assign qPop = hostPop || dropOldest;
   // Threshold acts as the queue limit when enabled
   assign qLimit = ctrl_ff[`PSQ_CTRL_STOP_BIT] ?
                   (qLevel >= {1'b0, thr_ff}) : !qNotFull;

   // Drain the ingress buffer according to the mode in force
   always_comb begin
      bufPop = 1'b0;
      qPush = 1'b0;
      dropOldest = 1'b0;
      case (effMode)
         PSQ_BYPASS: begin
            bufPop = bufValid;
         end
         PSQ_STORE: begin
            bufPop = bufValid;
            qPush = bufValid && !qLimit;
         end
         PSQ_STREAM: begin
            if (!qLimit || hostPop) begin
               bufPop = bufValid;
               qPush = bufValid;
            end else if (!readLock_ff) begin
               // Overwrite the oldest word unless the host is half-way through reading it
               bufPop = bufValid;
               qPush = bufValid;
               dropOldest = bufValid && qValid;
            end
         end
         default: begin
            bufPop = bufValid;
         end
      endcase
   end

   a_stop_limit: assert property (
      effMode == PSQ_STORE && ctrl_ff[`PSQ_CTRL_STOP_BIT] &&
      qLevel == {1'b0, thr_ff} && !hostPop |=> qLevel == $past(qLevel))
      else $error("Store mode grew past the threshold");

   // Partial queue word read in progress
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         readLock_ff <= 1'b0;
      end else if (byteRead) begin
         readLock_ff <= (curAddr >= `PSQ_ADDR_Q_PRESS_LO) &&
                        (curAddr < `PSQ_ADDR_Q_TEMP_HI);
      end else if (accessStart) begin
         readLock_ff <= 1'b0;
      end
   end

   // Queue status flags
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         thrReached_ff <= 1'b0;
         full_ff <= 1'b0;
         overwrite_ff <= 1'b0;
      end else begin
         thrReached_ff <= (qLevel >= {1'b0, thr_ff});
         full_ff <= qLimit;
         if (dropOldest) begin
            overwrite_ff <= 1'b1;
         end else if (hostPop || qFlush) begin
            overwrite_ff <= 1'b0;
         end
      end
   end

   a_overwrite_flag: assert property (
      dropOldest |=> overwrite_ff && qLevel == $past(qLevel))
      else $error("Overwrite not flagged or level changed");
   a_thr_flag: assert property (
      $past(reset_n)
      |-> thrReached_ff == ($past(qLevel) >= {1'b0, $past(thr_ff)}))
      else $error("Threshold flag wrong");
   a_host_pop: assert property (
      hostPop && !qPush && !qFlush |=> qLevel == $past(qLevel) - 8'h01)
      else $error("Reading the last queue byte did not pop");

   // Read data selection; unmapped offsets read zero
   always_comb begin
      case (curAddr)
         `PSQ_ADDR_CTRL: rdByte = {4'h0, ctrl_ff};
         `PSQ_ADDR_THR: rdByte = {1'b0, thr_ff};
         `PSQ_ADDR_REF_LO: rdByte = ref_ff[7:0];
         `PSQ_ADDR_REF_HI: rdByte = ref_ff[15:8];
         `PSQ_ADDR_OFS_LO: rdByte = ofs_ff[7:0];
         `PSQ_ADDR_OFS_HI: rdByte = ofs_ff[15:8];
         `PSQ_ADDR_CAUSE: rdByte = {bootFlag_ff, 4'h0, iaFlag_ff,
                                    diffFlag_ff};
         `PSQ_ADDR_FILL: rdByte = qLevel;
         `PSQ_ADDR_Q_PRESS_LO: rdByte = qValid ? qHead[7:0] : 8'h00;
         `PSQ_ADDR_Q_PRESS_MID: rdByte = qValid ? qHead[15:8] : 8'h00;
         `PSQ_ADDR_Q_PRESS_HI: rdByte = qValid ? qHead[23:16] : 8'h00;
         `PSQ_ADDR_Q_TEMP_LO: rdByte = qValid ? qHead[31:24] : 8'h00;
         `PSQ_ADDR_Q_TEMP_HI: rdByte = qValid ? qHead[39:32] : 8'h00;
         default: rdByte = 8'h00;
      endcase
   end

   // Registered read answer
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData_ff <= 8'h00;
         rdValid_ff <= 1'b0;
      end else begin
         rdValid_ff <= byteRead;
         if (byteRead) begin
            rdData_ff <= rdByte;
         end
      end
   end

   a_thr_bit7: assert property (
      byteRead && curAddr == `PSQ_ADDR_THR
      |=> rdValid_ff && !rdData_ff[7] && rdData_ff[6:0] == $past(thr_ff))
      else $error("Threshold read-back wrong");
   a_fill_read: assert property (
      byteRead && curAddr == `PSQ_ADDR_FILL |=> rdData_ff == $past(qLevel))
      else $error("Fill level read-back wrong");
   a_burst_wrap: assert property (
      byteRead && addrAutoInc && curAddr == `PSQ_ADDR_Q_TEMP_HI
      |=> addr_ff == `PSQ_ADDR_Q_PRESS_LO)
      else $error("Queue burst did not wrap");

   assign rdData = rdData_ff;
   assign rdValid = rdValid_ff;
   assign referencePressure = ref_ff;
   assign thresholdReached = thrReached_ff;
   assign queueOverwrite = overwrite_ff;
   assign queueFull = full_ff;
endmodule : psq_sample_queue_ctrl

// ==== sim/psq_host_model.sv ====
// Host model driving the byte strobes of the register port
module psq_host_model (
   input wire logic clk,
   output logic accessStart,
   output logic [7:0] accessAddr,
   output logic regWrite,
   output logic regRead,
   output logic [7:0] regWrData,
   input wire logic [7:0] rdData,
   input wire logic rdValid
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle strobes from time zero
   initial begin
      accessStart = 1'b0;
      accessAddr = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      regWrData = 8'h00;
   end
   // One byte access, held for one edge, then released
   task acc(input logic ld, input logic [7:0] a, input logic w,
      input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      accessStart <= ld;
      accessAddr <= a;
      regWrite <= w;
      regRead <= !w;
      regWrData <= d;
      @(posedge clk);
      accessStart <= 1'b0;
      regWrite <= 1'b0;
      regRead <= 1'b0;
      // Released lines no longer show the old value
      accessAddr <= ~a;
      regWrData <= ~d;
      @(negedge clk);
      q = (w || rdValid === 1'b1) ? rdData : 8'hxx;
   endtask : acc
endmodule : psq_host_model

// ==== sim/pressure_sample_queue_control_tb.sv ====
// Self-checking bench of the sample queue control block
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin \
 errCount++; $display("wrong value %0t %h %h", $time, (a), (e)); end end
module pressure_sample_queue_control_tb import psq_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, reset_n = 1'b0, sampleValid = 1'b0;
   logic bootRunning = 1'b0, referenceCaptureMode = 1'b0, autoInc = 1'b1;
   logic [2:0] pz = 3'h0;
   logic [23:0] samplePressure = 24'h0;
   logic [15:0] sampleTemperature = 16'h0, refValue = 16'h0, ofs;
   logic accessStart, regWrite, regRead, rdValid, sampleReady;
   logic [7:0] accessAddr, regWrData, rdData, q;
   logic [15:0] referencePressure;
   logic thresholdReached, queueOverwrite, queueFull;
   logic [39:0] w;
   logic [31:0] rs = 32'he8a4;
   logic [7:0] md[8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
      8'h06, 8'h07};
   int errCount = 0, samplesChecked = 0, cycles = 0;
   psq_sample_queue_ctrl #(.QUEUE_DEPTH(8)) dut (.clk, .reset_n,
      .accessStart, .accessAddr, .regWrite, .regRead, .regWrData,
      .addrAutoInc(autoInc), .rdData, .rdValid, .sampleValid,
      .samplePressure, .sampleTemperature, .sampleReady, .bootRunning,
      .pressureHighEvent(pz[0]), .pressureLowEvent(pz[1]),
      .zeroOnEnableMode(1'b0), .referenceCaptureMode, .refLoad(pz[2]),
      .refValue, .referencePressure, .thresholdReached, .queueOverwrite,
      .queueFull);
   psq_host_model host (.clk, .accessStart, .accessAddr, .regWrite,
      .regRead, .regWrData, .rdData, .rdValid);
   always #10 clk = ~clk;
   // Xorshift source, fixed seed
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : rnd
   // Stored pressure is the sample less the sign-extended offset
   function automatic logic [23:0] expP(logic [23:0] p, logic [15:0] o);
      return p - {{8{o[15]}}, o};
   endfunction : expP
   task wr(input logic [7:0] a, input logic [7:0] d);
      host.acc(1'b1, a, 1'b1, d, q);
   endtask : wr
   task rd(input logic [7:0] a);
      host.acc(1'b1, a, 1'b0, 8'h00, q);
   endtask : rd
   // Offer n random samples, each held until taken
   task push(input int n);
      repeat (n) begin
         @(posedge clk);
         sampleValid <= 1'b1;
         samplePressure <= 24'(rnd());
         sampleTemperature <= 16'(rnd());
         do @(negedge clk); while (sampleReady !== 1'b1);
      end
      @(posedge clk);
      sampleValid <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : push
   task pulse(input int k);
      @(posedge clk);
      pz[k] <= 1'b1;
      @(posedge clk);
      pz <= 3'h0;
   endtask : pulse
   task printVerdict();
      $display("checks %0d mismatches %0d", samplesChecked, errCount);
      if (errCount == 0 && samplesChecked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : printVerdict
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errCount++;
         printVerdict();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      foreach (md[i]) begin
         rd(8'h13 + 8'(i));
         if (i != 4 && i != 7) `CHK(q, 8'h00)
      end
      wr(8'h14, 8'hff);
      rd(8'h14);
      `CHK(q, 8'h7f)
      @(posedge clk) autoInc <= 1'b0;
      rd(8'h14);
      host.acc(1'b0, 8'h00, 1'b0, 8'h00, q);
      `CHK(q, 8'h7f)
      @(posedge clk) autoInc <= 1'b1;
      wr(8'h15, 8'h5a);
      rd(8'h15);
      `CHK(q, 8'h00)
      $display("end registers");
      ofs = 16'(rnd());
      wr(8'h18, ofs[7:0]);
      wr(8'h19, ofs[15:8]);
      rd(8'h19);
      `CHK(q, ofs[15:8])
      wr(8'h13, 8'h02);
      push(1);
      rd(8'h25);
      `CHK(q, 8'h01)
      w = {sampleTemperature, expP(samplePressure, ofs)};
      rd(8'h78);
      `CHK(q, w[7:0])
      for (int i = 1; i < 5; i++) begin
         host.acc(1'b0, 8'h00, 1'b0, 8'h00, q);
         `CHK(q, w[8*i+:8])
      end
      rd(8'h25);
      `CHK(q, 8'h00)
      $display("end read-out");
      foreach (md[i]) begin
         wr(8'h13, 8'h00);
         wr(8'h13, md[i]);
         push(2);
         rd(8'h25);
         `CHK(q, (i % 4 == 0 || i == 5 || i == 6) ? 8'h00 : 8'h02)
      end
      wr(8'h13, 8'h06);
      pulse(0);
      rd(8'h24);
      `CHK(q, 8'h05)
      push(2);
      rd(8'h25);
      `CHK(q, 8'h02)
      @(posedge clk) bootRunning <= 1'b1;
      pulse(1);
      rd(8'h24);
      `CHK(q, 8'h86)
      rd(8'h24);
      `CHK(q, 8'h80)
      $display("end modes and events");
      for (int m = 1; m < 3; m++) begin
         wr(8'h13, 8'h00);
         wr(8'h13, 8'(m));
         push(10);
         rd(8'h25);
         `CHK(q, 8'h08)
         `CHK(queueOverwrite, 1'(m == 2))
      end
      wr(8'h13, 8'h00);
      wr(8'h14, 8'h03);
      wr(8'h13, 8'h09);
      push(6);
      rd(8'h25);
      `CHK(q, 8'h03)
      `CHK({queueFull, thresholdReached}, 2'b11)
      `CHK(sampleReady, 1'b1)
      $display("end fill");
      @(posedge clk) refValue <= 16'(rnd());
      pulse(2);
      @(negedge clk);
      `CHK(referencePressure, 16'h0000)
      @(posedge clk) referenceCaptureMode <= 1'b1;
      pulse(2);
      rd(8'h16);
      `CHK(q, refValue[15:8])
      $display("end reference");
      printVerdict();
   end
endmodule : pressure_sample_queue_control_tb
